// File: rtl/lbk_block.sv
/*
 Logic block top: four slices in two columns, configuration store for
 generator tables and slice control words, carry, shift and wide-mux chains.
 Assumes routing-side inputs are on the mclk domain and loads happen while
 cfg_mode is high.
*/
`default_nettype none

module lbk_block #(
	parameter int NUM_SLICES = lbk_pkg::NUM_SLICES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic cfg_mode,
	input wire logic cfg_we,
	input wire logic [3:0] cfg_addr,
	input wire logic [15:0] cfg_data,
	input wire logic [31:0] lut_in,
	input wire logic [3:0] bx,
	input wire logic [3:0] by,
	input wire logic [3:0] ce,
	input wire logic [3:0] sr,
	input wire logic [1:0] carry_in,
	input wire logic shift_in,
	input wire logic f8_cascade_in,
	output logic [3:0] x_out,
	output logic [3:0] y_out,
	output logic [3:0] xq,
	output logic [3:0] yq,
	output logic [3:0] sum_x,
	output logic [3:0] sum_y,
	output logic [1:0] carry_out,
	output logic shift_out,
	output logic f7_out,
	output logic f8_out,
	output logic cfg_done
);

	logic [15:0] ctrl_q [4];
	logic [15:0] ctrl_d [4];
	logic done_q, done_d;
	logic [3:0] we_f, we_g, ci, co, sh_in, sh_out, f5, fx, fx_in0, fx_in1;
	logic [3:0] lut_f, lut_g;
	logic load_ok;

	////////////////////////////////////////////////////////////////////////
	// Configuration decode: tables and control words only while loading
	assign load_ok = cfg_mode && cfg_we && cfg_addr <= lbk_pkg::CFG_LAST;

	always_comb begin
		for (int s = 0; s < 4; s++) begin
			we_f[s] = load_ok && cfg_addr == lbk_pkg::CFG_LUT_BASE + 4'(2 * s);
			we_g[s] = load_ok && cfg_addr == lbk_pkg::CFG_LUT_BASE + 4'(2 * s + 1);
		end
	end

	// Control word next values
	always_comb begin
		for (int s = 0; s < 4; s++) begin
			ctrl_d[s] = ctrl_q[s];
			if (load_ok && cfg_addr == lbk_pkg::CFG_CTRL_BASE + 4'(s)) begin
				ctrl_d[s] = cfg_data;
			end
		end
		done_d = done_q;
		if (cfg_mode) begin
			done_d = 1'b0;
		end else begin
			done_d = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int s = 0; s < 4; s++) begin
				ctrl_q[s] <= lbk_pkg::CTRL_RESET;
			end
			done_q <= 1'b0;
		end else begin
			for (int s = 0; s < 4; s++) begin
				ctrl_q[s] <= ctrl_d[s];
			end
			done_q <= done_d;
		end
	end
	assign cfg_done = done_q;

	////////////////////////////////////////////////////////////////////////
	// Columns: slices 0,1 form column 0, slices 2,3 form column 1
	assign ci[0] = carry_in[0];
	assign ci[1] = co[0];
	assign ci[2] = carry_in[1];
	assign ci[3] = co[2];
	assign carry_out = {co[3], co[1]};

	// One shift chain through all four slices
	assign sh_in = {sh_out[2:0], shift_in};
	assign shift_out = sh_out[3];

	////////////////////////////////////////////////////////////////////////
	// Wide cascade: slices 0,2 six-input, slice 1 seven, slice 3 eight
	assign fx_in0[0] = f5[0];
	assign fx_in1[0] = f5[1];
	assign fx_in0[2] = f5[2];
	assign fx_in1[2] = f5[3];
	assign fx_in0[1] = fx[0];
	assign fx_in1[1] = fx[2];
	assign fx_in0[3] = fx[1];
	assign fx_in1[3] = f8_cascade_in;
	assign f7_out = fx[1];
	assign f8_out = fx[3];

	////////////////////////////////////////////////////////////////////////
	// The four slices around the switch matrix
	for (genvar s = 0; s < NUM_SLICES; s++) begin : g_slice
		lbk_slice u_slice (
			.mclk(mclk),
			.reset(reset),
			.cfg_we_f(we_f[s]),
			.cfg_we_g(we_g[s]),
			.cfg_data(cfg_data),
			.ctrl(ctrl_q[s]),
			.f_in(lut_in[8 * s +: 4]),
			.g_in(lut_in[8 * s + 4 +: 4]),
			.bx(bx[s]),
			.by(by[s]),
			.ce(ce[s]),
			.sr(sr[s]),
			.ci(ci[s]),
			.shift_in(sh_in[s]),
			.fx_in0(fx_in0[s]),
			.fx_in1(fx_in1[s]),
			.lut_f(lut_f[s]),
			.lut_g(lut_g[s]),
			.x(x_out[s]),
			.y(y_out[s]),
			.xq(xq[s]),
			.yq(yq[s]),
			.sum_x(sum_x[s]),
			.sum_y(sum_y[s]),
			.co(co[s]),
			.shift_out(sh_out[s]),
			.f5_out(f5[s]),
			.fx_out(fx[s])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_ctrl_frozen;
		@(posedge mclk) disable iff (reset)
		!cfg_mode |=> $stable(ctrl_q[0]) && $stable(ctrl_q[1]) && $stable(ctrl_q[2]) && $stable(ctrl_q[3]);
	endproperty
	a_ctrl_frozen: assert property (p_ctrl_frozen) else $error("control changed outside load");

	property p_carry_col;
		@(posedge mclk) disable iff (reset)
		(&{lut_f[1:0], lut_g[1:0]}) |-> carry_out[0] == carry_in[0];
	endproperty
	a_carry_col: assert property (p_carry_col) else $error("column 0 carry not propagated");

	property p_f8_cascade;
		@(posedge mclk) disable iff (reset)
		by[3] |-> f8_out == f8_cascade_in;
	endproperty
	a_f8_cascade: assert property (p_f8_cascade) else $error("eight-input stage ignores cascade");

	property p_f7_path;
		@(posedge mclk) disable iff (reset)
		(!by[1] && !by[0] && !bx[0]) |-> f7_out == lut_f[0];
	endproperty
	a_f7_path: assert property (p_f7_path) else $error("seven-input path wrong");

	property p_carry_col1;
		@(posedge mclk) disable iff (reset)
		(&{lut_f[3:2], lut_g[3:2]}) |-> carry_out[1] == carry_in[1];
	endproperty
	a_carry_col1: assert property (p_carry_col1) else $error("column 1 carry not propagated");

	property p_col1_gen;
		@(posedge mclk) disable iff (reset)
		!lut_g[3] |-> carry_out[1] == by[3];
	endproperty
	a_col1_gen: assert property (p_col1_gen) else $error("column 1 carry not generated");

	property p_carry_gen;
		@(posedge mclk) disable iff (reset)
		!lut_g[0] |-> co[0] == by[0];
	endproperty
	a_carry_gen: assert property (p_carry_gen) else $error("carry mux ignores generator");

	property p_sum_col;
		@(posedge mclk) disable iff (reset)
		lut_f[0] |-> sum_x[0] != carry_in[0];
	endproperty
	a_sum_col: assert property (p_sum_col) else $error("sum gate wrong");

	property p_f6_lower;
		@(posedge mclk) disable iff (reset)
		(by[0] && !bx[1] && !by[1] && !by[3]) |-> f8_out == lut_f[1];
	endproperty
	a_f6_lower: assert property (p_f6_lower) else $error("six-input stage wrong");

	property p_done;
		@(posedge mclk) disable iff (reset)
		cfg_mode |=> !cfg_done;
	endproperty
	a_done: assert property (p_done) else $error("done flag during load");

endmodule

`default_nettype wire

// File: rtl/lbk_pkg.sv
/*
 Shared constants and types for the logic block: configuration word map,
 slice control field positions and generator mode encodings.
 Assumes a single synchronous clock domain and no software-visible registers.
*/
`default_nettype none

package lbk_pkg;

	////////////////////////////////////////////////////////////////////////
	// Block shape
	localparam int NUM_SLICES = 4;
	localparam int LUT_INPUTS = 4;
	localparam int LUT_BITS = 16;
	localparam int CTRL_BITS = 16;

	////////////////////////////////////////////////////////////////////////
	// Configuration word addresses
	localparam logic [3:0] CFG_LUT_BASE = 4'h0;
	localparam logic [3:0] CFG_CTRL_BASE = 4'h8;
	localparam logic [3:0] CFG_LAST = 4'hb;

	////////////////////////////////////////////////////////////////////////
	// Slice control word field positions
	localparam int F_MODE_F = 0;
	localparam int F_MODE_G = 2;
	localparam int F_X_WIDE = 4;
	localparam int F_Y_WIDE = 5;
	localparam int F_DX_BYP = 6;
	localparam int F_DY_BYP = 7;
	localparam int F_LATCH = 8;
	localparam int F_SR_SYNC = 9;
	localparam int F_SR_HIGH = 10;
	localparam int F_REV_EN = 11;
	localparam int F_INIT_X = 12;
	localparam int F_INIT_Y = 13;
	localparam int F_CE_USED = 14;
	localparam int F_SR_USED = 15;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [15:0] LUT_RESET = 16'h0000;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// Generator operating modes
	typedef enum logic [1:0] {
		LBK_MODE_LUT = 2'h0,
		LBK_MODE_RAM = 2'h1,
		LBK_MODE_SHIFT = 2'h3
	} lbk_mode_t;

endpackage

`default_nettype wire

// File: rtl/lbk_slice.sv
/*
 One slice: two 4-input generators (table, memory or shift mode), five-input
 combine mux, one wide cascade mux stage, two carry stages, two storage elements.
 Assumes its control word and table loads come from the enclosing logic block.
*/
`default_nettype none

module lbk_slice (
	input wire logic mclk,
	input wire logic reset,
	input wire logic cfg_we_f,
	input wire logic cfg_we_g,
	input wire logic [15:0] cfg_data,
	input wire logic [15:0] ctrl,
	input wire logic [3:0] f_in,
	input wire logic [3:0] g_in,
	input wire logic bx,
	input wire logic by,
	input wire logic ce,
	input wire logic sr,
	input wire logic ci,
	input wire logic shift_in,
	input wire logic fx_in0,
	input wire logic fx_in1,
	output logic lut_f,
	output logic lut_g,
	output logic x,
	output logic y,
	output logic xq,
	output logic yq,
	output logic sum_x,
	output logic sum_y,
	output logic co,
	output logic shift_out,
	output logic f5_out,
	output logic fx_out
);

	logic [15:0] tab_q [2];
	logic [15:0] tab_d [2];
	lbk_pkg::lbk_mode_t mode [2];
	logic [3:0] addr [2];
	logic [1:0] wdat, sin, cfg_we, lut, q_q, q_d, d2, qv, init;
	logic ce_eff, sr_eff, rev, set_c, rst_c, async_m, cy_f;

	////////////////////////////////////////////////////////////////////////
	// Generator inputs, each with its own four pins
	assign mode[0] = lbk_pkg::lbk_mode_t'(ctrl[lbk_pkg::F_MODE_F +: 2]);
	assign mode[1] = lbk_pkg::lbk_mode_t'(ctrl[lbk_pkg::F_MODE_G +: 2]);
	assign addr[0] = f_in;
	assign addr[1] = g_in;
	assign wdat = {by, bx};
	assign sin = {tab_q[0][15], shift_in};
	assign cfg_we = {cfg_we_g, cfg_we_f};
	assign ce_eff = ctrl[lbk_pkg::F_CE_USED] ? ce : 1'b1;

	// Table contents: load, memory write or shift
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			tab_d[i] = tab_q[i];
			if (cfg_we[i]) begin
				tab_d[i] = cfg_data;
			end else if (mode[i] == lbk_pkg::LBK_MODE_RAM && sr && ce_eff) begin
				tab_d[i][addr[i]] = wdat[i];
			end else if (mode[i] == lbk_pkg::LBK_MODE_SHIFT && ce_eff) begin
				tab_d[i] = {tab_q[i][14:0], sin[i]};
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			tab_q[0] <= lbk_pkg::LUT_RESET;
			tab_q[1] <= lbk_pkg::LUT_RESET;
		end else begin
			tab_q[0] <= tab_d[0];
			tab_q[1] <= tab_d[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Table read, wide muxes and carry
	assign lut[0] = tab_q[0][addr[0]];
	assign lut[1] = tab_q[1][addr[1]];
	assign lut_f = lut[0];
	assign lut_g = lut[1];
	assign f5_out = bx ? lut[1] : lut[0];
	assign fx_out = by ? fx_in1 : fx_in0;
	assign x = ctrl[lbk_pkg::F_X_WIDE] ? f5_out : lut[0];
	assign y = ctrl[lbk_pkg::F_Y_WIDE] ? fx_out : lut[1];
	assign cy_f = lut[0] ? ci : bx;
	assign sum_x = lut[0] ^ ci;
	assign co = lut[1] ? cy_f : by;
	assign sum_y = lut[1] ^ cy_f;
	assign shift_out = tab_q[1][15];

	////////////////////////////////////////////////////////////////////////
	// Storage elements: set, reset and enable resolution
	assign d2[0] = ctrl[lbk_pkg::F_DX_BYP] ? bx : lut[0];
	assign d2[1] = ctrl[lbk_pkg::F_DY_BYP] ? by : lut[1];
	assign init = {ctrl[lbk_pkg::F_INIT_Y], ctrl[lbk_pkg::F_INIT_X]};
	assign sr_eff = ctrl[lbk_pkg::F_SR_USED] & sr;
	assign rev = ctrl[lbk_pkg::F_SR_USED] & ctrl[lbk_pkg::F_REV_EN] & by;
	assign set_c = ctrl[lbk_pkg::F_SR_HIGH] ? sr_eff : rev;
	assign rst_c = ctrl[lbk_pkg::F_SR_HIGH] ? rev : sr_eff;
	assign async_m = ~ctrl[lbk_pkg::F_SR_SYNC];

	always_comb begin
		q_d = q_q;
		if (rst_c) begin
			q_d = 2'h0;
		end else if (set_c) begin
			q_d = 2'h3;
		end else if (ce_eff) begin
			q_d = d2;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			q_q <= init;
		end else begin
			q_q <= q_d;
		end
	end

	// Output view: async clear over preset, then latch transparency
	always_comb begin
		if (async_m && rst_c) begin
			qv = 2'h0;
		end else if (async_m && set_c) begin
			qv = 2'h3;
		end else if (ctrl[lbk_pkg::F_LATCH] && ce_eff) begin
			qv = d2;
		end else begin
			qv = q_q;
		end
	end
	assign xq = qv[0];
	assign yq = qv[1];

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_tab_frozen;
		@(posedge mclk) disable iff (reset)
		(mode[0] == lbk_pkg::LBK_MODE_LUT && !cfg_we_f) |=> $stable(tab_q[0]);
	endproperty
	a_tab_frozen: assert property (p_tab_frozen) else $error("table changed outside load");

	property p_shift;
		@(posedge mclk) disable iff (reset)
		(mode[0] == lbk_pkg::LBK_MODE_SHIFT && !cfg_we_f && ce_eff)
			|=> tab_q[0][0] == $past(shift_in) && tab_q[0][15:1] == $past(tab_q[0][14:0]);
	endproperty
	a_shift: assert property (p_shift) else $error("shift step wrong");

	property p_d_path;
		@(posedge mclk) disable iff (reset)
		(!ctrl[lbk_pkg::F_DX_BYP] && !rst_c && !set_c && ce_eff && !ctrl[lbk_pkg::F_LATCH])
			|=> xq == $past(lut[0]) || !$stable(ctrl);
	endproperty
	a_d_path: assert property (p_d_path) else $error("storage missed generator output");

	property p_rst_win;
		@(posedge mclk) disable iff (reset)
		(set_c && rst_c) |-> ##1 (q_q == 2'h0);
	endproperty
	a_rst_win: assert property (p_rst_win) else $error("set beat reset");

	property p_ce_default;
		@(posedge mclk) disable iff (reset)
		(!ctrl[lbk_pkg::F_CE_USED] && !ce && !rst_c && !set_c) |=> q_q == $past(d2);
	endproperty
	a_ce_default: assert property (p_ce_default) else $error("unused enable blocked load");

	property p_latch;
		@(posedge mclk) disable iff (reset)
		(ctrl[lbk_pkg::F_LATCH] && ce_eff && !rst_c && !set_c) |-> yq == d2[1];
	endproperty
	a_latch: assert property (p_latch) else $error("latch not transparent");

endmodule

`default_nettype wire

// File: tb/lbk_nbr_model.sv
/*
 Model of the neighbouring slices and routing that feed the block's chain
 inputs: carry into both columns, shift chain and eight-input cascade.
 Assumes requests from the bench change just after the rising edge of mclk.
*/
`default_nettype none

module lbk_nbr_model (
	input wire logic mclk,
	input wire logic reset,
	input wire logic shift_req,
	input wire logic [1:0] carry_req,
	input wire logic casc_req,
	output logic [1:0] carry_in,
	output logic shift_in,
	output logic f8_cascade_in
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////
	// Neighbour outputs are registered, so they move only on the edge
	always_ff @(posedge mclk) begin
		if (reset) begin
			carry_in <= 2'h0;
			shift_in <= 1'h0;
			f8_cascade_in <= 1'h0;
		end else begin
			carry_in <= carry_req;
			shift_in <= shift_req;
			f8_cascade_in <= casc_req;
		end
	end
endmodule

`default_nettype wire

// File: tb/tb.sv
/*
 Self-checking bench for the logic block: tables, storage, set/reset, shift.
 Assumes the neighbour model drives the chain inputs of the block.
*/
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk, reset, cfg_mode, cfg_we, shift_req, casc_req;
	logic [3:0] cfg_addr, bx, by, ce, sr, x_out, y_out, xq, yq, sum_x, sum_y;
	logic [15:0] cfg_data;
	logic [31:0] lut_in;
	logic [1:0] carry_in, carry_out, carry_req;
	logic shift_in, f8_cascade_in, shift_out, f7_out, f8_out, cfg_done;
	logic [15:0] tab [8];
	int error_cnt, num_checks, cyc;

	lbk_nbr_model nbr (.mclk(mclk), .reset(reset), .shift_req(shift_req), .carry_req(carry_req),
		.casc_req(casc_req), .carry_in(carry_in), .shift_in(shift_in), .f8_cascade_in(f8_cascade_in));

	lbk_block dut (.mclk(mclk), .reset(reset), .cfg_mode(cfg_mode), .cfg_we(cfg_we),
		.cfg_addr(cfg_addr), .cfg_data(cfg_data), .lut_in(lut_in), .bx(bx), .by(by), .ce(ce),
		.sr(sr), .carry_in(carry_in), .shift_in(shift_in), .f8_cascade_in(f8_cascade_in),
		.x_out(x_out), .y_out(y_out), .xq(xq), .yq(yq), .sum_x(sum_x), .sum_y(sum_y),
		.carry_out(carry_out), .shift_out(shift_out), .f7_out(f7_out), .f8_out(f8_out),
		.cfg_done(cfg_done));

	////////////////////////////////////////////////////////////////////////
	// Common tasks
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Strobe stays high; the caller drops it after the last word
	task automatic cfg_wr(input logic [3:0] a, input logic [15:0] d);
		cfg_we = 1'b1;
		cfg_addr = a;
		cfg_data = d;
		tick(1);
	endtask

	task automatic do_reset;
		reset = 1'b1;
		tick(10);
		reset = 1'b0;
		cfg_mode = 1'b1;
		lut_in = 32'h0;
	endtask

	task automatic tally_and_finish;
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic s_lut;
		do_reset();
		chk("x_out reset", 16'h0, {12'h0, x_out});
		chk("cfg_done reset", 16'h0, {15'h0, cfg_done});
		for (int i = 0; i < 8; i++) begin
			tab[i] = 16'h9ac3 ^ (16'h1357 * i[15:0]);
			cfg_wr(i[3:0], tab[i]);
		end
		cfg_wr(4'hc, 16'hffff);
		cfg_we = 1'b0;
		cfg_mode = 1'b0;
		tick(1);
		chk("cfg_done", 16'h1, {15'h0, cfg_done});
		cfg_wr(4'h0, 16'h0);
		cfg_we = 1'b0;
		for (int v = 0; v < 16; v++) begin
			lut_in = {4{4'(15 - v), v[3:0]}};
			#1;
			for (int s = 0; s < 4; s++) begin
				chk("x_out", {15'h0, tab[2 * s][v]}, {15'h0, x_out[s]});
				chk("y_out", {15'h0, tab[2 * s + 1][15 - v]}, {15'h0, y_out[s]});
			end
		end
	endtask

	task automatic s_store;
		do_reset();
		ce = 4'h0;
		cfg_wr(4'h0, 16'hffff);
		cfg_we = 1'b0;
		tick(1);
		chk("xq load", 16'h1, {15'h0, xq[0]});
		chk("yq load", 16'h0, {15'h0, yq[0]});
		cfg_wr(4'h8, 16'h4000);
		cfg_wr(4'h0, 16'h0);
		cfg_we = 1'b0;
		tick(2);
		chk("xq held", 16'h1, {15'h0, xq[0]});
		cfg_wr(4'h8, 16'h4100);
		cfg_we = 1'b0;
		chk("latch closed", 16'h1, {15'h0, xq[0]});
		ce = 4'h1;
		#1;
		chk("latch open", 16'h0, {15'h0, xq[0]});
	endtask

	task automatic s_sr;
		do_reset();
		by = 4'h0;
		sr = 4'h1;
		cfg_wr(4'h8, 16'h8e00);
		cfg_we = 1'b0;
		tick(1);
		chk("sync set", 16'h1, {15'h0, xq[0]});
		by = 4'h1;
		#1;
		chk("sync wait", 16'h1, {15'h0, xq[0]});
		tick(1);
		chk("sync reset wins", 16'h0, {15'h0, xq[0]});
		by = 4'h0;
		tick(1);
		cfg_wr(4'h8, 16'h8c00);
		cfg_we = 1'b0;
		chk("async set", 16'h1, {15'h0, xq[0]});
		by = 4'h1;
		#1;
		chk("async clear wins", 16'h0, {15'h0, xq[0]});
		sr = 4'h0;
		by = 4'h0;
	endtask

	task automatic s_shift;
		do_reset();
		cfg_wr(4'h8, 16'h0003);
		cfg_we = 1'b0;
		cfg_mode = 1'b0;
		shift_req = 1'b1;
		tick(1);
		shift_req = 1'b0;
		tick(1);
		chk("shift bit0", 16'h1, {15'h0, x_out[0]});
		lut_in = 32'h1;
		#1;
		chk("shift bit1 old", 16'h0, {15'h0, x_out[0]});
		tick(1);
		chk("shift bit1", 16'h1, {15'h0, x_out[0]});
	endtask

	// Wide muxes, cascade input, both carry columns, shift chain end
	task automatic s_wide;
		do_reset();
		for (int s = 0; s < 4; s++) begin
			cfg_wr(4'(2 * s), 16'h0003);
			cfg_wr(4'(2 * s + 1), (s == 3) ? 16'h8002 : 16'h0002);
			cfg_wr(4'(8 + s), 16'h0030);
		end
		cfg_we = 1'b0;
		cfg_mode = 1'b0;
		bx = 4'h5;
		by = 4'h0;
		tick(1);
		chk("shift_out", 16'h1, {15'h0, shift_out});
		chk("x_out five-input", 16'ha, {12'h0, x_out});
		chk("y_out cascade", 16'h0, {12'h0, y_out});
		chk("f7_out", 16'h0, {15'h0, f7_out});
		chk("f8_out", 16'h0, {15'h0, f8_out});
		by = 4'h1;
		tick(1);
		chk("y_out cascade", 16'hb, {12'h0, y_out});
		chk("f7_out", 16'h1, {15'h0, f7_out});
		chk("f8_out", 16'h1, {15'h0, f8_out});
		by = 4'h8;
		casc_req = 1'b1;
		tick(1);
		chk("y_out cascade", 16'h8, {12'h0, y_out});
		chk("f7_out", 16'h0, {15'h0, f7_out});
		chk("f8_out", 16'h1, {15'h0, f8_out});
		casc_req = 1'b0;
		bx = 4'h0;
		by = 4'h0;
		lut_in = 32'h11111111;
		carry_req = 2'h1;
		tick(1);
		chk("sum_x", 16'hc, {12'h0, sum_x});
		chk("sum_y", 16'hc, {12'h0, sum_y});
		chk("carry_out", 16'h1, {14'h0, carry_out});
		carry_req = 2'h2;
		tick(1);
		chk("sum_x", 16'h3, {12'h0, sum_x});
		chk("sum_y", 16'h3, {12'h0, sum_y});
		chk("carry_out", 16'h2, {14'h0, carry_out});
		carry_req = 2'h0;
	endtask

	// Memory mode writes under sr, storage fed from bx bypass
	task automatic s_ram;
		do_reset();
		cfg_wr(4'h8, 16'h0041);
		cfg_we = 1'b0;
		cfg_mode = 1'b0;
		lut_in = 32'h5;
		bx = 4'h1;
		sr = 4'h1;
		tick(1);
		chk("ram write", 16'h1, {15'h0, x_out[0]});
		chk("xq bypass", 16'h1, {15'h0, xq[0]});
		sr = 4'h0;
		bx = 4'h0;
		lut_in = 32'h4;
		tick(1);
		chk("ram other bit", 16'h0, {15'h0, x_out[0]});
		chk("xq bypass", 16'h0, {15'h0, xq[0]});
		bx = 4'h1;
		tick(1);
		chk("ram write disabled", 16'h0, {15'h0, x_out[0]});
		lut_in = 32'h5;
		tick(1);
		chk("ram held", 16'h1, {15'h0, x_out[0]});
		bx = 4'h0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Clock, timeout and main sequence
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	initial begin
		reset = 1'b1;
		cfg_mode = 1'b0;
		cfg_we = 1'b0;
		cfg_addr = 4'h0;
		cfg_data = 16'h0;
		lut_in = 32'h0;
		bx = 4'h0;
		by = 4'h0;
		ce = 4'h0;
		sr = 4'h0;
		shift_req = 1'b0;
		carry_req = 2'h0;
		casc_req = 1'b0;
		#1;
		s_lut();
		s_store();
		s_sr();
		s_shift();
		s_wide();
		s_ram();
		tally_and_finish();
	end
endmodule

`default_nettype wire
